// ===== rtl/vip_pkg.sv
// Package: register map, field layout and carrier types of the interrupt prioritizer
package vip_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] VIP_OFF_FLAGS = 8'h00;
    localparam logic [7:0] VIP_OFF_ENABLE = 8'h04;
    localparam logic [7:0] VIP_OFF_SCI_ERR = 8'h08;
    localparam logic [7:0] VIP_OFF_RST_EN = 8'h0C;
    localparam logic [7:0] VIP_OFF_PENDING = 8'h10;
    localparam logic [7:0] VIP_OFF_VECTOR = 8'h14;
    localparam logic [7:0] VIP_OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] VIP_OFF_IRQ_MASK = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int VIP_SCI_EN_POS = 8;
    localparam int VIP_RSTEN_WDOG_POS = 0;
    localparam int VIP_RSTEN_BROWN_POS = 1;
    localparam int VIP_VEC_VALID_POS = 7;
    localparam int VIP_VEC_ADDR_POS = 16;
    localparam int VIP_IRQ_TAKEN_POS = 0;
    localparam int VIP_IRQ_RESET_POS = 1;
    localparam logic [31:0] VIP_RST_ENABLE = 32'h0000_0000;
    localparam logic [1:0] VIP_RST_RST_EN = 2'h3;
    localparam logic [1:0] VIP_RST_IRQ_MASK = 2'h0;

    // ------------------------------------------------------------------
    // Vector table layout
    // ------------------------------------------------------------------
    localparam int VIP_NVEC = 32;
    localparam logic [15:0] VIP_VEC_TOP = 16'hFFFE;
    // Slots that have a source behind them; all others stay silent
    localparam logic [31:0] VIP_ASSIGNED = 32'h47B7_F86B;
    localparam int VIP_VEC_RESET = 0;
    localparam int VIP_VEC_SWI = 1;
    localparam int VIP_VEC_SCI_ERR = 16;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic watchdog_timeout;
        logic brownout_detect;
        logic illegal_opcode;
        logic illegal_addr;
    } vip_rst_src_t;

    typedef struct packed {
        logic overrun;
        logic noise;
        logic framing;
        logic parity;
    } vip_sci_err_t;

    typedef struct packed {
        logic valid;
        logic [4:0] num;
        logic [15:0] addr_hi;
        logic [15:0] addr_lo;
    } vip_vec_t;

    // Address of the high byte of a vector's service-routine pointer
    function automatic logic [15:0] vip_vec_addr(input logic [4:0] num);
        vip_vec_addr = VIP_VEC_TOP - {10'h000, num, 1'b0};
    endfunction : vip_vec_addr

endpackage : vip_pkg

// ===== rtl/vip_prio.sv
// Fixed-priority picker: lowest set index wins
`timescale 1ns/100ps
module vip_prio #(
    parameter int N = 32,
    parameter int W = 5
) (
    input wire logic [N-1:0] req,
    output logic valid,
    output logic [W-1:0] idx
);
    if (N < 2 || (1 << W) < N)
    begin : g_bad
        $error("vip_prio: N must be at least 2 and fit in W bits");
    end

    always_comb
    begin
        valid = 1'b0;
        idx = '0;
        // Walk down so the smallest requesting index is the last one kept
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                valid = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule : vip_prio

// ===== rtl/vip_top.sv
// Vectored interrupt prioritizer with APB register access
`timescale 1ns/100ps
// Function
// - Among pending requests grant the smallest vector number; 0 is highest.
// - Vector n sits at 0xFFFE-2n: high byte first, low byte next address.
// - Except vectors 0 and 1: event sets source flag; request forwarded only while local enable is 1.
// - Vector 0 shared by gated watchdog and brownout, pin, opcode, address faults.
module vip_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] src_event,
    input wire vip_pkg::vip_sci_err_t sci_err_event,
    input wire vip_pkg::vip_rst_src_t rst_src,
    input wire logic reset_pin_n,
    input wire logic software_trap_instruction,
    input wire logic vec_fetch,
    output logic core_irq_req,
    output logic reset_req,
    output vip_pkg::vip_vec_t vec_out,
    output logic irq
);
    import vip_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0] flags;
    logic [31:0] enable;
    logic [3:0] sci_flags;
    logic [3:0] sci_en;
    logic watchdog_reset_enable;
    logic brownout_reset_enable;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [2:0] pin_sync;
    logic pin_active;
    logic [31:0] req;
    logic win_valid;
    logic [4:0] win_idx;
    logic reset_cause;
    logic wr_en;
    logic rd_en;
    logic setup;
    logic [1:0] irq_set;

    assign setup = psel && !penable;
    // Upper address bits must be zero, or a stray access would alias onto a register
    assign wr_en = psel && penable && pwrite && paddr[31:8] == 24'h000000;
    assign rd_en = psel && penable && !pwrite && paddr[31:8] == 24'h000000;

    // ------------------------------------------------------------------
    // Reset pin filter
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync <= 3'h7;
            pin_active <= 1'b0;
        end
        else
        begin
            pin_sync <= {pin_sync[1:0], reset_pin_n};
            // A new level counts only once two late stages agree
            if (pin_sync[1] == pin_sync[2])
                pin_active <= !pin_sync[2];
        end
    end

    // ------------------------------------------------------------------
    // Request formation
    // ------------------------------------------------------------------
    assign reset_cause = (rst_src.watchdog_timeout && watchdog_reset_enable)
        || (rst_src.brownout_detect && brownout_reset_enable)
        || pin_active || rst_src.illegal_opcode || rst_src.illegal_addr;

    always_comb
    begin
        req = flags & enable;
        req[VIP_VEC_SCI_ERR] = |(sci_flags & sci_en);
        req[VIP_VEC_SWI] = software_trap_instruction;
        req[VIP_VEC_RESET] = reset_cause;
        req = req & VIP_ASSIGNED;
    end

    vip_prio #(
        .N(VIP_NVEC),
        .W(5)
    ) u_prio (
        .req(req),
        .valid(win_valid),
        .idx(win_idx)
    );

    // ------------------------------------------------------------------
    // Source flags: an event in the clearing cycle survives
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags <= '0;
        else if (wr_en && paddr[7:0] == VIP_OFF_FLAGS)
            flags <= ((flags & ~pwdata) | src_event) & VIP_ASSIGNED;
        else
            flags <= (flags | src_event) & VIP_ASSIGNED;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sci_flags <= '0;
        else if (wr_en && paddr[7:0] == VIP_OFF_SCI_ERR)
            sci_flags <= (sci_flags & ~pwdata[3:0]) | sci_err_event;
        else
            sci_flags <= sci_flags | sci_err_event;
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable <= VIP_RST_ENABLE;
            sci_en <= '0;
            watchdog_reset_enable <= VIP_RST_RST_EN[VIP_RSTEN_WDOG_POS];
            brownout_reset_enable <= VIP_RST_RST_EN[VIP_RSTEN_BROWN_POS];
            irq_mask <= VIP_RST_IRQ_MASK;
        end
        else if (wr_en)
        begin
            if (paddr[7:0] == VIP_OFF_ENABLE)
                enable <= pwdata & VIP_ASSIGNED;
            else if (paddr[7:0] == VIP_OFF_SCI_ERR)
                sci_en <= pwdata[VIP_SCI_EN_POS +: 4];
            else if (paddr[7:0] == VIP_OFF_RST_EN)
            begin
                watchdog_reset_enable <= pwdata[VIP_RSTEN_WDOG_POS];
                brownout_reset_enable <= pwdata[VIP_RSTEN_BROWN_POS];
            end
            else if (paddr[7:0] == VIP_OFF_IRQ_MASK)
                irq_mask <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------------
    // Registered so the core samples a settled winner; costs one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_irq_req <= 1'b0;
            reset_req <= 1'b0;
            vec_out <= '0;
        end
        else
        begin
            core_irq_req <= |req[VIP_NVEC-1:1];
            reset_req <= req[VIP_VEC_RESET];
            if (win_valid)
            begin
                vec_out.valid <= 1'b1;
                vec_out.num <= win_idx;
                vec_out.addr_hi <= vip_vec_addr(win_idx);
                vec_out.addr_lo <= vip_vec_addr(win_idx) + 16'h0001;
            end
            else
                vec_out <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status: read clears, set wins
    // ------------------------------------------------------------------
    always_comb
    begin
        irq_set = '0;
        // The core fetches whatever wins at that moment
        irq_set[VIP_IRQ_TAKEN_POS] = vec_fetch && vec_out.valid;
        irq_set[VIP_IRQ_RESET_POS] = reset_cause;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= '0;
        else if (rd_en && paddr[7:0] == VIP_OFF_IRQ_STATUS)
            irq_status <= irq_set;
        else
            irq_status <= irq_status | irq_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |((irq_status | irq_set) & irq_mask)
                && !(rd_en && paddr[7:0] == VIP_OFF_IRQ_STATUS && !(|(irq_set & irq_mask)));
    end

    // ------------------------------------------------------------------
    // APB slave: data and error decided in setup, steady through access
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
            if (paddr[31:8] != 24'h000000 || paddr[1:0] != 2'h0)
                pslverr <= 1'b1;
            else if (paddr[7:0] == VIP_OFF_FLAGS)
                prdata <= flags;
            else if (paddr[7:0] == VIP_OFF_ENABLE)
                prdata <= enable;
            else if (paddr[7:0] == VIP_OFF_SCI_ERR)
                prdata <= {20'h00000, sci_en, 4'h0, sci_flags};
            else if (paddr[7:0] == VIP_OFF_RST_EN)
                prdata <= {30'h00000000, brownout_reset_enable, watchdog_reset_enable};
            else if (paddr[7:0] == VIP_OFF_PENDING)
                prdata <= req;
            else if (paddr[7:0] == VIP_OFF_VECTOR)
                prdata <= {vec_out.addr_hi, 8'h00, vec_out.valid, 2'h0, vec_out.num};
            else if (paddr[7:0] == VIP_OFF_IRQ_STATUS)
                prdata <= {30'h00000000, irq_status | irq_set};
            else if (paddr[7:0] == VIP_OFF_IRQ_MASK)
                prdata <= {30'h00000000, irq_mask};
            else
                pslverr <= 1'b1;
        end
    end

endmodule : vip_top

// ===== tb/vectored_interrupt_prioritizer_bench.sv
// Bench: scenarios for the interrupt prioritizer
`timescale 1ns/100ps
module vectored_interrupt_prioritizer_bench;
    import vip_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rearm, e, irq;
    logic reset_pin_n, software_trap_instruction, vec_fetch, core_irq_req, reset_req;
    logic [31:0] paddr, pwdata, prdata, src_event, r;
    logic [4:0] got_num;
    vip_sci_err_t sci_err_event;
    vip_rst_src_t rst_src;
    vip_vec_t vec_out;
    int miscompares, n_tests, cyc;
    vip_top uut (.*);
    vip_core_model core (.*);
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic summarize;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    always @(posedge pclk)
        if (++cyc == 20000)
        begin
            miscompares++;
            summarize();
        end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt
    // Read data is taken in the access cycle, 1 ns after its opening edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, 24'h000000, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        wt(0);
        while (pready !== 1'b1)
            wt(1);
        {r, e} = {prdata, pslverr};
        @(posedge pclk);
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h00000000);
        chk("prdata", r, x);
    endtask : rd
    task automatic ev(input logic [31:0] s, input logic [3:0] q);
        @(posedge pclk);
        {src_event, sci_err_event} <= {s, q};
        @(posedge pclk);
        {src_event, sci_err_event} <= 36'h0;
        wt(2);
    endtask : ev
    task automatic vec(input logic [4:0] n);
        chk("valid", vec_out.valid, 1'b1);
        chk("num", vec_out.num, n);
        chk("addr_hi", vec_out.addr_hi, 16'hFFFE - {n, 1'b0});
        chk("addr_lo", vec_out.addr_lo, 16'hFFFF - {n, 1'b0});
    endtask : vec
    task automatic t_regs;
        rd(VIP_OFF_RST_EN, 32'h00000003);
        chk("pslverr", e, 1'b0);
        rd(VIP_OFF_IRQ_MASK, 32'h00000000);
        rd(VIP_OFF_ENABLE, VIP_RST_ENABLE);
        rd(8'h20, 32'h00000000);
        chk("pslverr", e, 1'b1);
    endtask : t_regs
    task automatic t_prio;
        apb(1'b1, VIP_OFF_ENABLE, 32'hFFFFFFFF);
        apb(1'b1, VIP_OFF_IRQ_MASK, 32'h00000001);
        rearm <= 1'b1;
        @(posedge pclk);
        rearm <= 1'b0;
        ev(32'h40000020, 4'h0);
        vec(5'd5);
        chk("core_irq_req", core_irq_req, 1'b1);
        rd(VIP_OFF_PENDING, 32'h40000020);
        rd(VIP_OFF_VECTOR, 32'hFFF40085);
        for (int i = 0; i < 20 && got_num === 5'h1F; i++)
            wt(1);
        chk("fetched", got_num, 5'd5);
        wt(1);
        chk("irq", irq, 1'b1);
        rd(VIP_OFF_IRQ_STATUS, 32'h00000001);
        wt(1);
        chk("irq", irq, 1'b0);
        apb(1'b1, VIP_OFF_FLAGS, 32'h00000020);
        wt(1);
        vec(5'd30);
        apb(1'b1, VIP_OFF_FLAGS, 32'h40000000);
        wt(1);
        chk("valid", vec_out.valid, 1'b0);
        chk("idle addr_hi", vec_out.addr_hi, 32'h00000000);
    endtask : t_prio
    task automatic t_gate;
        apb(1'b1, VIP_OFF_ENABLE, 32'h00000000);
        ev(32'h00001000, 4'h0);
        chk("core_irq_req", core_irq_req, 1'b0);
        rd(VIP_OFF_FLAGS, 32'h00001000);
        apb(1'b1, VIP_OFF_ENABLE, 32'hFFFFFFFF);
        wt(1);
        vec(5'd12);
        apb(1'b1, VIP_OFF_FLAGS, 32'h00001000);
        ev(~VIP_ASSIGNED, 4'h0);
        chk("core_irq_req", core_irq_req, 1'b0);
        rd(VIP_OFF_FLAGS, 32'h00000000);
    endtask : t_gate
    task automatic t_sci;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, VIP_OFF_SCI_ERR, 32'h100 << ((i + 1) % 4));
            ev(32'h0, 4'(1 << i));
            chk("core_irq_req", core_irq_req, 1'b0);
            apb(1'b1, VIP_OFF_SCI_ERR, 32'h100 << i);
            wt(1);
            vec(5'd16);
            apb(1'b1, VIP_OFF_SCI_ERR, (32'h100 << i) | (32'h1 << i));
        end
    endtask : t_sci
    task automatic t_rst;
        for (int i = 0; i < 8; i++)
        begin
            if (i == 4)
                apb(1'b1, VIP_OFF_RST_EN, 32'h00000000);
            @(posedge pclk);
            rst_src <= 4'(8 >> (i % 4));
            wt(2);
            chk("reset_req", reset_req, 1'(i < 4 || i > 5));
        end
        chk("irq masked", irq, 1'b0);
        rd(VIP_OFF_IRQ_STATUS, 32'h00000002);
        @(posedge pclk);
        {rst_src, reset_pin_n} <= 5'h00;
        wt(8);
        chk("pin", reset_req, 1'b1);
        @(posedge pclk);
        reset_pin_n <= 1'b1;
        ev(32'h00000008, 4'h0);
        @(posedge pclk);
        software_trap_instruction <= 1'b1;
        wt(2);
        vec(5'd1);
        @(posedge pclk);
        software_trap_instruction <= 1'b0;
        wt(2);
        vec(5'd3);
    endtask : t_rst
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, rearm} = '0;
        {src_event, sci_err_event, rst_src, software_trap_instruction} = '0;
        reset_pin_n = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_prio();
        t_gate();
        t_sci();
        t_rst();
        summarize();
    end
endmodule : vectored_interrupt_prioritizer_bench

// ===== tb/vip_core_model.sv
// Core model: finishes, stacks, then masks and fetches the vector in the same cycle
`timescale 1ns/100ps
module vip_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rearm,
    input wire logic core_irq_req,
    input wire vip_pkg::vip_vec_t vec_out,
    output logic vec_fetch,
    output logic [4:0] got_num
);
    import vip_pkg::*;
    logic mask;
    logic [2:0] cnt;
    // Mask set out of reset; only the bench clears it, so no nesting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {mask, cnt, vec_fetch, got_num} <= {1'b1, 3'h0, 1'b0, 5'h1F};
        else
        begin
            vec_fetch <= 1'b0;
            if (rearm)
                mask <= 1'b0;
            else if (core_irq_req && !mask)
                cnt <= cnt + 3'h1;
            if (cnt == 3'h5)
                {mask, cnt, vec_fetch, got_num} <= {1'b1, 3'h0, 1'b1, vec_out.num};
        end
    end
endmodule : vip_core_model

// ===== tb/vip_props.sv
// Checker: port-level properties of the interrupt prioritizer
`timescale 1ns/100ps
module vip_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire vip_pkg::vip_rst_src_t rst_src,
    input wire logic reset_pin_n,
    input wire logic software_trap_instruction,
    input wire logic core_irq_req,
    input wire logic reset_req,
    input wire logic irq,
    input wire vip_pkg::vip_vec_t vec_out
);
    import vip_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_hi;
        vec_out.valid |-> vec_out.addr_hi == 16'hFFFE - {10'h000, vec_out.num, 1'b0};
    endproperty
    a_hi: assert property (p_hi) else $error("addr_hi off");
    property p_lo; vec_out.valid |-> vec_out.addr_lo == vec_out.addr_hi + 16'h0001; endproperty
    a_lo: assert property (p_lo) else $error("addr_lo off");
    property p_idle; !vec_out.valid |-> vec_out == '0; endproperty
    a_idle: assert property (p_idle) else $error("idle vector not zero");
    property p_free; vec_out.valid |-> VIP_ASSIGNED[vec_out.num]; endproperty
    a_free: assert property (p_free) else $error("empty slot won");
    property p_zero; reset_req |-> vec_out.valid && vec_out.num == 5'h00; endproperty
    a_zero: assert property (p_zero) else $error("reset lost priority");
    property p_core; vec_out.valid && vec_out.num != 5'h00 |-> core_irq_req; endproperty
    a_core: assert property (p_core) else $error("winner not requested");
    property p_trap; software_trap_instruction [*2] |=> vec_out.valid && !vec_out.num[4:1]; endproperty
    a_trap: assert property (p_trap) else $error("trap not granted");
    property p_ilop; rst_src.illegal_opcode [*2] |=> reset_req; endproperty
    a_ilop: assert property (p_ilop) else $error("opcode fault ignored");
    property p_pin; !reset_pin_n [*6] |=> reset_req; endproperty
    a_pin: assert property (p_pin) else $error("pin reset ignored");
    c_req: cover property ($rose(core_irq_req));
    c_rst: cover property ($rose(reset_req));
    c_irq: cover property ($rose(irq));
endmodule : vip_props
bind vip_top vip_props u_props (.*);
